//--- pkg/arb_pkg.sv
// Purpose: Constants shared by the submission queue arbiter
// Assumes: Avalon-MM byte addresses, 32-bit data
// Notes: Level codes above the low level count as low
package arb_pkg;
  localparam int AW = 8;
  localparam int CW = 9;
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_WEIGHT = 8'h04;
  localparam logic [AW-1:0] OFS_URGENT = 8'h08;
  localparam logic [AW-1:0] OFS_LEVEL = 8'h0c;
  localparam logic [AW-1:0] OFS_CAP = 8'h10;
  localparam logic [AW-1:0] OFS_STATUS = 8'h14;
  localparam logic [AW-1:0] OFS_CREDIT = 8'h18;
  localparam int CTRL_MECH_BIT = 0;
  localparam int CTRL_BURST_LSB = 8;
  localparam int WEIGHT_HIGH_LSB = 16;
  localparam int WEIGHT_MED_LSB = 8;
  localparam int WEIGHT_LOW_LSB = 0;
  localparam int CAP_WRR_BIT = 0;
  localparam int STAT_CUR_LSB = 0;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_FSM_LSB = 20;
  localparam int CRED_STRIDE = 10;
  localparam logic MECH_RR = 1'b0;
  localparam logic MECH_WRR = 1'b1;
  localparam logic [2:0] BURST_RST = 3'h0;
  localparam logic [7:0] WEIGHT_RST = 8'h00;
  localparam logic [1:0] LVL_HIGH = 2'h0;
  localparam logic [1:0] LVL_MED = 2'h1;
  localparam logic [1:0] LVL_LOW = 2'h2;
  localparam int PTR_ALL = 0;
  localparam int PTR_URG = 1;
  localparam int PTR_LVL = 2;
  typedef enum logic [1:0] {
    ST_ARB = 2'h1,
    ST_BURST = 2'h2
  } fsm_t;
endpackage : arb_pkg

//--- rtl/sq_arbiter.sv
// Purpose: Picks the submission queue that starts the next commands
// Assumes: Queue 0 is the admin queue; pending flags are synchronous
// Notes: One start pulse at most every second cycle
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - Plain round robin rotates over all queues
// - Plain round robin gives every queue equal priority
// - Several commands per turn, up to burst
// - Weighted mode: three classes, three weighted levels
// - Higher class commands start before lower ones
// - Weighted mode: admin queue outranks every other queue
// - Urgent after admin, before weighted, no fairness
// - Weighted round robin shares bandwidth among levels
// - Level weights come from host settings
// - Round robin among queues of one level
// - Weighted turn: lesser of burst and credits
// - Final selector forwards highest priority candidate
// - No more starts than burst before rearbitration, a fused pair counting as one
// - Round robin always; weighted mode advertised
// - Fused pair starts together, counts as one
module sq_arbiter
  import arb_pkg::*;
#(
  parameter int NQ = 8,
  parameter logic WRR_SUPPORTED = 1'b1
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NQ-1:0] sq_pending,
  input wire logic [NQ-1:0] sq_fused_first,
  input wire logic start_ready,
  output logic cmd_start,
  output logic [$clog2(NQ)-1:0] cmd_sq,
  output logic cmd_fused
);
  localparam int QW = $clog2(NQ);

  typedef struct packed {
    fsm_t st;
    logic mech;
    logic [2:0] burst;
    logic [2:0][7:0] wt;
    logic [NQ-1:0] urg;
    logic [2*NQ-1:0] lvl;
    logic [QW-1:0] cur;
    logic [CW-1:0] cnt;
    logic hold;
    logic wq;
    logic [1:0] lsel;
    logic [2:0][CW-1:0] cred;
    logic [4:0][QW-1:0] ptr;
    logic start;
    logic [QW-1:0] sq;
    logic fused;
    logic wait_r;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [NQ-1:0] um;
  logic [2:0][NQ-1:0] lm;
  logic [2:0] elig;
  logic [CW-1:0] blen;
  logic reload;

  function automatic logic [QW-1:0] rr_pick(
    input logic [NQ-1:0] m,
    input logic [QW-1:0] last
  );
    logic [QW-1:0] r;
    logic f;
    int j;
    r = last;
    f = 1'b0;
    j = 0;
    for (int i = 1; i <= NQ; i++)
    begin
      j = (int'(last) + i) % NQ;
      if (!f && m[j])
      begin
        r = QW'(j);
        f = 1'b1;
      end
    end
    return r;
  endfunction : rr_pick

  function automatic logic [1:0] lvl_pick(
    input logic [2:0] e,
    input logic [1:0] last
  );
    logic [1:0] r;
    logic f;
    int j;
    r = last;
    f = 1'b0;
    j = 0;
    for (int i = 1; i <= 3; i++)
    begin
      j = (int'(last) + i) % 3;
      if (!f && e[j])
      begin
        r = 2'(j);
        f = 1'b1;
      end
    end
    return r;
  endfunction : lvl_pick

  always_comb
  begin
    logic [1:0] lv;
    logic [1:0] l;
    logic req;
    logic pre;
    lv = LVL_HIGH;
    l = LVL_HIGH;
    pre = 1'b0;
    s_d = s_q;
    s_d.start = 1'b0;
    blen = CW'(1) << s_q.burst;
    um = sq_pending & s_q.urg & ~NQ'(1);
    lm = '0;
    for (int q = 1; q < NQ; q++)
    begin
      lv = s_q.lvl[2*q +: 2];
      if (lv > LVL_LOW)
        lv = LVL_LOW;
      if (sq_pending[q] && !s_q.urg[q])
        lm[lv][q] = 1'b1;
    end
    for (int k = 0; k < 3; k++)
      elig[k] = (|lm[k]) && (s_q.cred[k] != '0);
    reload = 1'b0;
    // Register slave: one wait cycle, then the access completes
    req = avs_read || avs_write;
    s_d.wait_r = 1'b1;
    if (req && s_q.wait_r)
    begin
      s_d.wait_r = 1'b0;
      s_d.rdata = '0;
      if (avs_address == OFS_CTRL)
      begin
        s_d.rdata[CTRL_MECH_BIT] = s_q.mech;
        s_d.rdata[CTRL_BURST_LSB +: 3] = s_q.burst;
      end
      else if (avs_address == OFS_WEIGHT)
        s_d.rdata = {8'h00, s_q.wt[0], s_q.wt[1], s_q.wt[2]};
      else if (avs_address == OFS_URGENT)
        s_d.rdata[NQ-1:0] = s_q.urg;
      else if (avs_address == OFS_LEVEL)
        s_d.rdata[2*NQ-1:0] = s_q.lvl;
      else if (avs_address == OFS_CAP)
        s_d.rdata[CAP_WRR_BIT] = WRR_SUPPORTED;
      else if (avs_address == OFS_STATUS)
      begin
        s_d.rdata[STAT_CUR_LSB +: QW] = s_q.cur;
        s_d.rdata[STAT_CNT_LSB +: CW] = s_q.cnt;
        s_d.rdata[STAT_FSM_LSB +: 2] = s_q.st;
      end
      else if (avs_address == OFS_CREDIT)
        for (int k = 0; k < 3; k++)
          s_d.rdata[CRED_STRIDE*k +: CW] = s_q.cred[k];
    end
    if (avs_write && !s_q.wait_r)
    begin
      if (avs_address == OFS_CTRL)
      begin
        s_d.mech = avs_writedata[CTRL_MECH_BIT] & WRR_SUPPORTED;
        s_d.burst = avs_writedata[CTRL_BURST_LSB +: 3];
      end
      else if (avs_address == OFS_WEIGHT)
      begin
        s_d.wt[0] = avs_writedata[WEIGHT_HIGH_LSB +: 8];
        s_d.wt[1] = avs_writedata[WEIGHT_MED_LSB +: 8];
        s_d.wt[2] = avs_writedata[WEIGHT_LOW_LSB +: 8];
      end
      else if (avs_address == OFS_URGENT)
        s_d.urg = avs_writedata[NQ-1:0] & ~NQ'(1);
      else if (avs_address == OFS_LEVEL)
        s_d.lvl = avs_writedata[2*NQ-1:0];
    end
    case (s_q.st)
      ST_ARB:
      begin
        s_d.hold = 1'b0;
        if (s_q.mech == MECH_RR)
        begin
          if (|sq_pending)
          begin
            s_d.cur = rr_pick(sq_pending, s_q.ptr[PTR_ALL]);
            s_d.ptr[PTR_ALL] = s_d.cur;
            s_d.cnt = blen;
            s_d.wq = 1'b0;
            s_d.st = ST_BURST;
          end
        end
        else if (sq_pending[0])
        begin
          s_d.cur = '0;
          s_d.cnt = blen;
          s_d.wq = 1'b0;
          s_d.st = ST_BURST;
        end
        else if (|um)
        begin
          s_d.cur = rr_pick(um, s_q.ptr[PTR_URG]);
          s_d.ptr[PTR_URG] = s_d.cur;
          s_d.cnt = blen;
          s_d.wq = 1'b0;
          s_d.st = ST_BURST;
        end
        else if (|elig)
        begin
          l = lvl_pick(elig, s_q.lsel);
          s_d.lsel = l;
          s_d.cur = rr_pick(lm[l], s_q.ptr[PTR_LVL+l]);
          s_d.ptr[PTR_LVL+l] = s_d.cur;
          s_d.cnt = (blen < s_q.cred[l]) ? blen : s_q.cred[l];
          s_d.wq = 1'b1;
          s_d.st = ST_BURST;
        end
        else if (|lm)
        begin
          reload = 1'b1;
          for (int k = 0; k < 3; k++)
            s_d.cred[k] = CW'(s_q.wt[k]) + CW'(1);
        end
      end
      ST_BURST:
      begin
        pre = (s_q.mech == MECH_WRR) &&
          ((s_q.cur != '0 && sq_pending[0]) || (s_q.wq && |um));
        if (!s_q.start && start_ready && sq_pending[s_q.cur] &&
            (s_q.hold || !pre))
        begin
          s_d.start = 1'b1;
          s_d.sq = s_q.cur;
          s_d.fused = sq_fused_first[s_q.cur] && !s_q.hold;
          if (s_d.fused)
            s_d.hold = 1'b1;
          else
          begin
            s_d.hold = 1'b0;
            s_d.cnt = s_q.cnt - CW'(1);
            if (s_q.wq)
              s_d.cred[s_q.lsel] = s_q.cred[s_q.lsel] - CW'(1);
            if (s_q.cnt == CW'(1))
              s_d.st = ST_ARB;
          end
        end
        else if (!s_q.hold && !s_q.start &&
                 (!sq_pending[s_q.cur] || pre))
          s_d.st = ST_ARB;
      end
      default:
        s_d.st = ST_ARB;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.st <= ST_ARB;
      s_q.mech <= MECH_RR;
      s_q.burst <= BURST_RST;
      s_q.wt <= {3{WEIGHT_RST}};
      s_q.wait_r <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_r;
  assign cmd_start = s_q.start;
  assign cmd_sq = s_q.sq;
  assign cmd_fused = s_q.fused;

  a_rr_all_queues: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == ST_ARB && s_q.mech == MECH_RR && sq_pending == NQ'(1))
    |=> (s_q.st == ST_BURST && s_q.cur == '0))
    else $error("round robin skipped the admin queue");

  a_admin_wins: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == ST_ARB && s_q.mech == MECH_WRR && sq_pending[0])
    |=> (s_q.cur == '0 && !s_q.wq))
    else $error("admin queue not chosen first");

  a_urgent_next: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == ST_ARB && s_q.mech == MECH_WRR && !sq_pending[0] && |um)
    |=> (s_q.urg[s_q.cur] && s_q.st == ST_BURST))
    else $error("urgent queue not chosen after admin");

  a_strict_preempt: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == ST_BURST && s_q.wq && !s_q.hold && !s_q.start &&
     s_q.mech == MECH_WRR && (sq_pending[0] || |um))
    |=> (s_q.st == ST_ARB && !cmd_start))
    else $error("weighted burst kept running over higher class");

  a_burst_bound: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == ST_BURST) |-> (s_q.cnt <= blen && s_q.cnt != '0))
    else $error("burst count out of range");

  a_credit_cap: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == ST_ARB && $past(s_q.st) == ST_BURST && s_q.wq)
    or (s_q.st == ST_BURST && s_q.wq) |-> s_q.cnt <= s_q.cred[s_q.lsel])
    else $error("weighted burst exceeds credits");

  a_fused_pair: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (cmd_start && cmd_fused) |-> (s_q.hold && s_q.st == ST_BURST)
    ##1 (s_q.hold && s_q.cur == $past(cmd_sq)))
    else $error("fused pair split");

  a_start_current: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cmd_start |-> (cmd_sq == s_q.cur && $past(sq_pending[s_q.cur])))
    else $error("start from a queue not holding the turn");

  a_credit_reload: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reload |=> (s_q.cred[0] == CW'($past(s_q.wt[0])) + CW'(1) &&
                s_q.cred[2] == CW'($past(s_q.wt[2])) + CW'(1)))
    else $error("credits not reloaded from weights");

endmodule : sq_arbiter

//--- testbench/sq_host_model.sv
// Purpose: Host side that keeps commands waiting in each queue
// Assumes: Bench loads the per-queue command counts
// Notes: Head advances at the edge where a start is seen
`timescale 1ns/1ps
module sq_host_model
  import arb_pkg::*;
#(
  parameter int NQ = 8
)(
  input wire logic ref_clk,
  input wire logic cmd_start,
  input wire logic [$clog2(NQ)-1:0] cmd_sq,
  output logic [NQ-1:0] sq_pending
);
  int cnt [NQ];
  always_comb
  begin
    for (int q = 0; q < NQ; q++)
      sq_pending[q] = (cnt[q] != 0);
  end
  always @(posedge ref_clk)
  begin
    if (cmd_start === 1'b1 && cnt[cmd_sq] > 0)
      cnt[cmd_sq] <= cnt[cmd_sq] - 1;
  end
endmodule : sq_host_model

//--- testbench/tb_submission_queue_arbiter.sv
// Purpose: Self-checking bench for the submission queue arbiter
// Assumes: Host model holds the queue contents
// Notes: Order of starts is logged and compared
`timescale 1ns/1ps
module tb_submission_queue_arbiter
  import arb_pkg::*;
();
  localparam int NQ = 8;
  logic [NQ-1:0] fused_first = 8'h00;
  logic cmd_fused;
  logic fz_q [$];
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NQ-1:0] sq_pending;
  logic start_ready = 1'b0;
  logic cmd_start;
  logic [2:0] cmd_sq;
  logic [31:0] rd;
  int seed = 96;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int c [NQ];
  logic [2:0] log_q [$];

  always #5 ref_clk = ~ref_clk;

  sq_arbiter #(.NQ(NQ), .WRR_SUPPORTED(1'b1)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sq_pending(sq_pending),
    .sq_fused_first(fused_first), .start_ready(start_ready),
    .cmd_start(cmd_start), .cmd_sq(cmd_sq), .cmd_fused(cmd_fused)
  );
  sq_host_model #(.NQ(NQ)) i_host (
    .ref_clk(ref_clk), .cmd_start(cmd_start), .cmd_sq(cmd_sq),
    .sq_pending(sq_pending)
  );

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [AW-1:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    chk(n < 20, 1'b1);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  function automatic int occ(input logic [2:0] q, input int lo, hi);
    int k;
    k = 0;
    for (int i = lo; i < hi; i++)
      k += (log_q[i] === q);
    return k;
  endfunction : occ

  function automatic int share(input int w);
    return 8 * (w + 1) / 4;
  endfunction : share

  task automatic run(input string name);
    int tot;
    int n;
    tot = 0;
    n = 0;
    log_q.delete();
    fz_q.delete();
    for (int q = 0; q < NQ; q++)
    begin
      i_host.cnt[q] <= c[q];
      tot += c[q];
    end
    while (log_q.size() < tot && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    chk(log_q.size(), tot);
    $display("Test %s done", name);
  endtask : run

  always @(posedge ref_clk)
  begin
    start_ready <= 1'($random(seed));
    cycles <= cycles + 1;
    if (cmd_start === 1'b1)
    begin
      log_q.push_back(cmd_sq);
      fz_q.push_back(cmd_fused);
    end
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    int k;
    k = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'h0, OFS_CAP, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0001);
    bus(1'h0, OFS_CTRL, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    bus(1'h1, 8'h1c, 32'hffff_ffff, rd);
    bus(1'h0, 8'h1c, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    $display("Test regs done");
    c = '{2, 2, 2, 2, 2, 2, 2, 2};
    run("rotate");
    for (int i = 1; i < 16; i++)
      chk(log_q[i], 3'(log_q[i-1] + 1));
    bus(1'h1, OFS_CTRL, 32'h0000_0100, rd);
    c = '{4, 4, 4, 4, 4, 4, 4, 4};
    run("burst");
    for (int i = 2; i < 32; i++)
      chk(log_q[i], (i % 2) ? log_q[i-1] : 3'(log_q[i-2] + 1));
    bus(1'h1, OFS_CTRL, 32'h0000_0001, rd);
    bus(1'h1, OFS_URGENT, 32'h0000_0009, rd);
    bus(1'h0, OFS_URGENT, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0008);
    for (int q = 0; q < NQ; q++)
      c[q] = 1 + ($random(seed) & 3);
    run("strict");
    chk(occ(0, 0, c[0]), c[0]);
    chk(occ(3, c[0], c[0] + c[3]), c[3]);
    // Reset mid-run so credits and pointers start from a known state
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'h1, OFS_URGENT, 32'h0000_0000, rd);
    bus(1'h1, OFS_LEVEL, 32'h0000_0210, rd);
    bus(1'h1, OFS_WEIGHT, 32'h0001_0000, rd);
    bus(1'h1, OFS_CTRL, 32'h0000_0701, rd);
    bus(1'h0, OFS_WEIGHT, 32'h0000_0000, rd);
    chk(rd, 32'h0001_0000);
    c = '{0, 4, 4, 0, 4, 4, 0, 0};
    run("weighted");
    chk(occ(1, 0, 8), share(1) / 2);
    chk(occ(5, 0, 8), share(1) / 2);
    chk(occ(2, 0, 8), share(0));
    chk(occ(4, 0, 8), share(0));
    bus(1'h1, OFS_CTRL, 32'h0000_0000, rd);
    fused_first <= 8'h04;
    c = '{0, 0, 4, 0, 0, 0, 4, 0};
    run("fused");
    foreach (fz_q[i])
      k += int'(fz_q[i] === 1'b1);
    chk(occ(2, 0, 3), 2);
    chk(k, 2);
    end_of_test();
  end
endmodule : tb_submission_queue_arbiter
